// >>> hdl/rrt_pkg.sv
package rrt_pkg;

  // bus request as seen on the processor side pins, one beat per bus cycle
  typedef struct packed {
    logic valid;
    logic read_write;
    logic chip_select_two;
    logic chip_select_one;
    logic rom_region_select;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rrt_bus_req_t;

  // one peripheral port: output level and output enable per bit
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } rrt_port_drive_t;

  // address field positions
  localparam int ADDR_SEL_A0 = 0;
  localparam int ADDR_SEL_A1 = 1;
  localparam int ADDR_TIMER_A2 = 2;
  localparam int ADDR_IRQEN_A3 = 3;
  localparam int ADDR_A6 = 6;
  localparam int ADDR_A8 = 8;
  localparam int ADDR_A9 = 9;
  localparam int RAM_ADDR_BITS = 6;
  localparam int RAM_DEPTH = 64;
  localparam int ROM_ADDR_BITS = 10;
  localparam int FLAG_BIT = 7;
  localparam int PB_CS2_BIT = 5;
  localparam int PB_IRQ_BIT = 7;

  // register choice on a2..a0 while the i/o side is selected
  localparam logic [2:0] SEL_PORT_A_DATA = 3'h0;
  localparam logic [2:0] SEL_PORT_A_DIR = 3'h1;
  localparam logic [2:0] SEL_PORT_B_DATA = 3'h2;
  localparam logic [2:0] SEL_PORT_B_DIR = 3'h3;

  // prescale choice on a1..a0 during a timer write
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV8 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV64 = 2'h2;
  localparam logic [1:0] PRESCALE_DIV1024 = 2'h3;

  // prescaler reload: divide ratio minus one, in clock periods
  localparam logic [9:0] RELOAD_DIV1 = 10'h000;
  localparam logic [9:0] RELOAD_DIV8 = 10'h007;
  localparam logic [9:0] RELOAD_DIV64 = 10'h03f;
  localparam logic [9:0] RELOAD_DIV1024 = 10'h3ff;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [9:0] PRESCALE_ZERO = 10'h000;

endpackage

// >>> hdl/rrt_decode.sv
`timescale 1ns/1ns
module rrt_decode #(
  parameter logic [2:0] ROM_PATTERN = 3'h1,
  parameter logic [2:0] CHIP_CODE = 3'h0,
  parameter bit SINGLE_CHIP = 1'b1,
  parameter bit CS2_AS_PORT = 1'b1,
  parameter logic [7:0] ROM_SEED = 8'h5a
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire rrt_pkg::rrt_bus_req_t bus_req,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] port_a_in,
  output rrt_pkg::rrt_port_drive_t port_a_drive,
  input wire logic [7:0] port_b_in,
  output rrt_pkg::rrt_port_drive_t port_b_drive
);
  import rrt_pkg::*;

  logic rom_sel;
  logic ram_sel;
  logic io_sel;
  logic any_sel;
  logic cs2_level;
  logic [2:0] reg_pick;
  logic timer_side;
  logic timer_wr;
  logic timer_rd;
  logic flag_rd;
  logic timer_access;
  logic tick;
  logic flag_set;
  logic [7:0] rom_data;
  logic [7:0] rd_mux;
  logic [7:0] port_a_data_q;
  logic [7:0] port_a_dir_q;
  logic [7:0] port_b_data_q;
  logic [7:0] port_b_dir_q;
  logic [7:0] count_q;
  logic [9:0] pre_q;
  logic [1:0] prescale_q;
  logic flag_q;
  logic irq_en_q;
  logic [7:0] data_q;
  logic data_oe_q;
  logic [7:0] ram_mem [RAM_DEPTH];
  logic [7:0] pa_s1_q;
  logic [7:0] pa_s2_q;
  logic [7:0] pa_s3_q;
  logic [7:0] pa_pin_q;
  logic [7:0] pb_s1_q;
  logic [7:0] pb_s2_q;
  logic [7:0] pb_s3_q;
  logic [7:0] pb_pin_q;

  // prescaler reload for a divide choice
  function automatic logic [9:0] reload_for(input logic [1:0] pick);
    logic [9:0] r;
    case (pick)
      PRESCALE_DIV1: r = RELOAD_DIV1;
      PRESCALE_DIV8: r = RELOAD_DIV8;
      PRESCALE_DIV64: r = RELOAD_DIV64;
      default: r = RELOAD_DIV1024;
    endcase
    return r;
  endfunction

  // mask programmed rom contents, a fixed pattern of the address
  function automatic logic [7:0] rom_byte(input logic [ROM_ADDR_BITS-1:0] a);
    return a[7:0] ^ {6'h00, a[ROM_ADDR_BITS-1:ROM_ADDR_BITS-2]} ^ ROM_SEED;
  endfunction

  // chip select two drops out of every decode when it is a port pin
  // pin given to port
  assign cs2_level = CS2_AS_PORT ? 1'b0 : bus_req.chip_select_two;

  // chip selects
  // rom pattern match
  assign rom_sel = ({cs2_level, bus_req.chip_select_one, bus_req.rom_region_select}
                    == {CS2_AS_PORT ? 1'b0 : ROM_PATTERN[2], ROM_PATTERN[1:0]});
  assign ram_sel = !cs2_level && !bus_req.chip_select_one && !bus_req.rom_region_select
                   && !bus_req.addr[ADDR_A9]
                   && (SINGLE_CHIP || bus_req.addr[ADDR_A8] == CHIP_CODE[2])
                   && bus_req.addr[ADDR_A8-1:ADDR_A6] == CHIP_CODE[1:0];
  assign io_sel = !cs2_level && !bus_req.chip_select_one && !bus_req.rom_region_select
                  && bus_req.addr[ADDR_A9]
                  && bus_req.addr[ADDR_A8:ADDR_A6] == CHIP_CODE;
  assign any_sel = rom_sel || ram_sel || io_sel;

  // internal register choice
  assign reg_pick = bus_req.addr[ADDR_TIMER_A2:ADDR_SEL_A0];
  assign timer_side = bus_req.valid && io_sel && bus_req.addr[ADDR_TIMER_A2];
  assign timer_wr = timer_side && !bus_req.read_write;
  assign timer_rd = timer_side && bus_req.read_write && !bus_req.addr[ADDR_SEL_A0];
  assign flag_rd = timer_side && bus_req.read_write && bus_req.addr[ADDR_SEL_A0];
  assign timer_access = timer_wr || timer_rd;
  assign rom_data = rom_byte(bus_req.addr);

  // port pin synchronisers, value taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pa_s1_q <= BYTE_ZERO;
      pa_s2_q <= BYTE_ZERO;
      pa_s3_q <= BYTE_ZERO;
      pb_s1_q <= BYTE_ZERO;
      pb_s2_q <= BYTE_ZERO;
      pb_s3_q <= BYTE_ZERO;
    end else begin
      pa_s1_q <= port_a_in;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pb_s1_q <= port_b_in;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
    end
  end

  // per bit agreement filter on the settled pin values
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pa_pin_q[gi] <= 1'b0;
          pb_pin_q[gi] <= 1'b0;
        end else begin
          if (pa_s2_q[gi] == pa_s3_q[gi]) begin
            pa_pin_q[gi] <= pa_s3_q[gi];
          end
          if (pb_s2_q[gi] == pb_s3_q[gi]) begin
            pb_pin_q[gi] <= pb_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // port data and direction registers, cleared by reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_data_q <= BYTE_ZERO;
      port_a_dir_q <= BYTE_ZERO;
      port_b_data_q <= BYTE_ZERO;
      port_b_dir_q <= BYTE_ZERO;
    end else if (bus_req.valid && io_sel && !bus_req.read_write) begin
      case (reg_pick)
        SEL_PORT_A_DATA: port_a_data_q <= bus_req.wdata;
        SEL_PORT_A_DIR: port_a_dir_q <= bus_req.wdata;
        SEL_PORT_B_DATA: port_b_data_q <= bus_req.wdata;
        SEL_PORT_B_DIR: port_b_dir_q <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // ram write
  // byte write
  always_ff @(posedge ref_clk) begin
    if (bus_req.valid && ram_sel && !bus_req.read_write) begin
      ram_mem[bus_req.addr[RAM_ADDR_BITS-1:0]] <= bus_req.wdata;
    end
  end

  // interval timer: prescaler and count, divide by one once the flag is up
  assign tick = (pre_q == PRESCALE_ZERO);
  assign flag_set = tick && (count_q == BYTE_ZERO) && !timer_wr;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= BYTE_ZERO;
      pre_q <= PRESCALE_ZERO;
      prescale_q <= PRESCALE_DIV1;
    end else if (timer_wr) begin
      count_q <= bus_req.wdata;
      prescale_q <= bus_req.addr[ADDR_SEL_A1:ADDR_SEL_A0];
      pre_q <= reload_for(bus_req.addr[ADDR_SEL_A1:ADDR_SEL_A0]);
    end else if (tick) begin
      count_q <= count_q - 8'h01;
      pre_q <= (flag_q || flag_set) ? RELOAD_DIV1 : reload_for(prescale_q);
    end else begin
      pre_q <= pre_q - 10'h001;
    end
  end

  // interrupt flag: timeout sets, timer read or write clears, set wins over a read but a timer write blocks the set
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (timer_access) begin
      flag_q <= 1'b0;
    end
  end

  // interrupt enable taken from a3 on every timer write and count read, not on a flag read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= 1'b0;
    end else if (timer_access) begin
      irq_en_q <= bus_req.addr[ADDR_IRQEN_A3];
    end
  end

  // read data selection
  always_comb begin
    rd_mux = BYTE_ZERO;
    if (rom_sel) begin
      rd_mux = rom_data;
    end else if (ram_sel) begin
      rd_mux = ram_mem[bus_req.addr[RAM_ADDR_BITS-1:0]];
    end else if (bus_req.addr[ADDR_TIMER_A2]) begin
      rd_mux = bus_req.addr[ADDR_SEL_A0] ? {flag_q, 7'h00} : count_q;
    end else begin
      case (reg_pick)
        SEL_PORT_A_DATA: rd_mux = (port_a_data_q & port_a_dir_q) | (pa_pin_q & ~port_a_dir_q);
        SEL_PORT_A_DIR: rd_mux = port_a_dir_q;
        SEL_PORT_B_DATA: rd_mux = (port_b_data_q & port_b_dir_q) | (pb_pin_q & ~port_b_dir_q);
        SEL_PORT_B_DIR: rd_mux = port_b_dir_q;
        default: rd_mux = BYTE_ZERO;
      endcase
    end
  end

  // data bus answer, driven the cycle after a selected read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= BYTE_ZERO;
      data_oe_q <= 1'b0;
    end else if (bus_req.valid && bus_req.read_write && any_sel) begin
      data_q <= rd_mux;
      data_oe_q <= 1'b1;
    end else begin
      data_oe_q <= 1'b0;
    end
  end
  assign data_out = data_q;
  assign data_oe = data_oe_q;

  // peripheral pin drive
  assign port_a_drive.out = port_a_data_q;
  assign port_a_drive.oe = port_a_dir_q;
  always_comb begin
    port_b_drive.out = port_b_data_q;
    port_b_drive.oe = port_b_dir_q;
    // bit five idle when used as chip select
    if (!CS2_AS_PORT) begin
      port_b_drive.oe[PB_CS2_BIT] = 1'b0;
    end
    if (irq_en_q && flag_q) begin
      port_b_drive.out[PB_IRQ_BIT] = 1'b0;
      port_b_drive.oe[PB_IRQ_BIT] = 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_sel_read;
    bus_req.valid && bus_req.read_write;
  endsequence

  a_rom_read_data: assert property (
    s_sel_read and rom_sel |=> data_oe_q && data_q == $past(rom_data))
    else $error("rom read returned wrong byte");
  a_ram_byte_write: assert property (
    bus_req.valid && ram_sel && !bus_req.read_write
    |=> ram_mem[$past(bus_req.addr[RAM_ADDR_BITS-1:0])] == $past(bus_req.wdata))
    else $error("ram byte not written");
  a_port_a_dir: assert property (
    bus_req.valid && io_sel && !bus_req.read_write && reg_pick == SEL_PORT_A_DIR
    |=> port_a_dir_q == $past(bus_req.wdata) && port_a_drive.oe == port_a_dir_q)
    else $error("port a direction not loaded");
  a_port_b_dir: assert property (
    bus_req.valid && io_sel && !bus_req.read_write && reg_pick == SEL_PORT_B_DIR
    |=> port_b_dir_q == $past(bus_req.wdata))
    else $error("port b direction not loaded");
  a_port_a_data: assert property (
    bus_req.valid && io_sel && !bus_req.read_write && reg_pick == SEL_PORT_A_DATA
    |=> port_a_drive.out == $past(bus_req.wdata))
    else $error("port a data not loaded");
  a_port_b_data: assert property (
    bus_req.valid && io_sel && !bus_req.read_write && reg_pick == SEL_PORT_B_DATA
    |=> port_b_data_q == $past(bus_req.wdata))
    else $error("port b data not loaded");
  a_timer_load: assert property (
    timer_wr |=> count_q == $past(bus_req.wdata)
      && pre_q == reload_for($past(bus_req.addr[ADDR_SEL_A1:ADDR_SEL_A0])))
    else $error("timer load wrong");
  a_timer_read: assert property (
    timer_rd |=> data_oe_q && data_q == $past(count_q))
    else $error("timer read wrong");
  a_flag_read: assert property (
    flag_rd |=> data_q == {$past(flag_q), 7'h00})
    else $error("flag read wrong");
  a_irq_enable_a3: assert property (
    timer_access |=> irq_en_q == $past(bus_req.addr[ADDR_IRQEN_A3]))
    else $error("interrupt enable not taken from a3");
  a_sel_exclusive: assert property (
    rom_sel |-> !ram_sel && !io_sel)
    else $error("rom select overlaps another select");
  a_ram_a9_low: assert property (
    ram_sel |-> !bus_req.addr[ADDR_A9] && !bus_req.chip_select_one)
    else $error("ram select with a9 high");
  a_io_a9_high: assert property (
    io_sel |-> bus_req.addr[ADDR_A9] && !bus_req.rom_region_select)
    else $error("i/o select with a9 low");
  a_bus_idle_off: assert property (
    !(bus_req.valid && bus_req.read_write && any_sel) |=> !data_oe_q)
    else $error("data bus driven without select");

endmodule

// >>> dv/rrt_cpu_model.sv
`timescale 1ns/1ns
// processor side of the bus: one beat per call, answer taken one cycle later
module rrt_cpu_model (
  input wire logic ref_clk,
  output rrt_pkg::rrt_bus_req_t bus_req,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  import rrt_pkg::*;
  logic [7:0] rd_q;
  logic oe_q;

  // bus idle at time zero, valid low so nothing is accessed
  initial begin
    bus_req = '0;
    rd_q = 8'h00;
    oe_q = 1'b0;
  end

  // one access: request held over the taking edge, answer captured after it
  task automatic cycle(input logic rw, input logic [2:0] sel, input logic [9:0] a,
                       input logic [7:0] wd);
    @(posedge ref_clk);
    #1;
    bus_req.read_write = rw;
    {bus_req.chip_select_two, bus_req.chip_select_one, bus_req.rom_region_select} = sel;
    bus_req.addr = a;
    bus_req.wdata = wd;
    bus_req.valid = 1'b1;
    @(posedge ref_clk);
    #1;
    rd_q = data_out;
    oe_q = data_oe;
    // released lines show a changed value, not the last one
    bus_req.valid = 1'b0;
    bus_req.addr = ~a;
    bus_req.wdata = ~wd;
  endtask
endmodule

// >>> dv/rom_ram_io_timer_decode_tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module rom_ram_io_timer_decode_tb;
  import rrt_pkg::*;
  logic ref_clk;
  logic resetn;
  rrt_bus_req_t bus_req;
  logic [7:0] data_out;
  logic data_oe;
  logic [7:0] port_a_in;
  logic [7:0] port_b_in;
  rrt_port_drive_t port_a_drive;
  rrt_port_drive_t port_b_drive;
  int n_fail;
  int compares;
  logic [9:0] rom_a [4] = '{10'h3f0, 10'h3f7, 10'h00f, 10'h2c9};
  int divs [4] = '{1, 8, 64, 1024};

  rrt_decode dut_u (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus_req(bus_req),
    .data_out(data_out),
    .data_oe(data_oe),
    .port_a_in(port_a_in),
    .port_a_drive(port_a_drive),
    .port_b_in(port_b_in),
    .port_b_drive(port_b_drive)
  );

  rrt_cpu_model cpu_u (
    .ref_clk(ref_clk),
    .bus_req(bus_req),
    .data_out(data_out),
    .data_oe(data_oe)
  );

  // 10 mhz clock
  always #50 ref_clk = ~ref_clk;

  // rom content as the mask seeds it
  function automatic logic [7:0] rom_val(input logic [9:0] a);
    return a[7:0] ^ {6'h00, a[9:8]} ^ 8'h5a;
  endfunction

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    cpu_u.cycle(1'b0, 3'h0, a, d);
  endtask

  // read that must be answered with the given byte
  task automatic rd(input logic [2:0] sel, input logic [9:0] a, input logic [7:0] exp,
                    input string nm);
    cpu_u.cycle(1'b1, sel, a, 8'h00);
    `CHK(nm, 1'b1, cpu_u.oe_q)
    `CHK(nm, exp, cpu_u.rd_q)
  endtask

  // read that must leave the data bus undriven
  task automatic no_rd(input logic [2:0] sel, input logic [9:0] a, input string nm);
    cpu_u.cycle(1'b1, sel, a, 8'h00);
    `CHK(nm, 1'b0, cpu_u.oe_q)
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    port_a_in = 8'ha5;
    port_b_in = 8'h3c;
    n_fail = 0;
    compares = 0;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    `CHK("data_oe after reset", 1'b0, data_oe)
    // rom reads, low and high address bits varied
    for (int i = 0; i < 4; i++) begin
      rd(3'h1, rom_a[i], rom_val(rom_a[i]), "rom byte");
    end
    rd(3'h5, 10'h123, rom_val(10'h123), "rom with cs2 as port");
    no_rd(3'h3, 10'h123, "rom wrong pattern");
    $display("test rom done");
    // ram writes, one outside this chip's code
    wr(10'h015, 8'hc3);
    wr(10'h02a, 8'h3c);
    wr(10'h095, 8'hff);
    rd(3'h0, 10'h115, 8'hc3, "ram a8 ignored");
    rd(3'h0, 10'h02a, 8'h3c, "ram byte");
    rd(3'h0, 10'h015, 8'hc3, "ram after foreign write");
    no_rd(3'h0, 10'h095, "ram wrong code");
    $display("test ram done");
    // port registers, one write to a foreign i/o code
    wr(10'h201, 8'h0f);
    wr(10'h200, 8'h3c);
    wr(10'h203, 8'hff);
    wr(10'h202, 8'h96);
    wr(10'h240, 8'h11);
    rd(3'h0, 10'h201, 8'h0f, "port a direction");
    rd(3'h0, 10'h203, 8'hff, "port b direction");
    rd(3'h0, 10'h200, 8'hac, "port a data mixed");
    rd(3'h0, 10'h20a, 8'h96, "port b data a3 ignored");
    no_rd(3'h0, 10'h240, "io wrong code");
    `CHK("port a drive", 16'h3c0f, port_a_drive)
    `CHK("port b drive", 16'h96ff, port_b_drive)
    $display("test ports done");
    // timer load and immediate count read with a1 high
    wr(10'h207, 8'h40);
    rd(3'h0, 10'h206, 8'h40, "timer count");
    // each prescale: count 8 expires after about nine periods
    for (int p = 0; p < 4; p++) begin
      wr(10'h204 | 10'(p), 8'h08);
      repeat (4 * divs[p]) @(posedge ref_clk);
      rd(3'h0, 10'h205, 8'h00, "flag before expiry");
      repeat (6 * divs[p] + 10) @(posedge ref_clk);
      rd(3'h0, 10'h205, 8'h80, "flag after expiry");
      rd(3'h0, 10'h20f, 8'h80, "flag kept by flag read");
      cpu_u.cycle(1'b1, 3'h0, 10'h204, 8'h00);
      rd(3'h0, 10'h205, 8'h00, "flag cleared by timer read");
    end
    $display("test timer done");
    // interrupt on port b bit seven enabled by a3
    wr(10'h203, 8'h00);
    wr(10'h20c, 8'h01);
    repeat (10) @(posedge ref_clk);
    `CHK("irq pin low", 2'b01, {port_b_drive.out[7], port_b_drive.oe[7]})
    cpu_u.cycle(1'b1, 3'h0, 10'h204, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK("irq pin released", 1'b0, port_b_drive.oe[7])
    // all port b bits inputs now, so the read shows the pins
    rd(3'h0, 10'h202, 8'h3c, "port b data pins");
    $display("test irq done");
    final_report();
  end

  // watchdog well beyond the expected run of about 11100 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    $display("Error watchdog expected finish seen hang");
    final_report();
  end
endmodule
